//--- rpcr_consts.svh
// Offsets, field positions, reset values and codes of the radio config bank
`ifndef RPCR_CONSTS_SVH
`define RPCR_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RPCR_OFF_CRC_SEED   12'h53c
`define RPCR_OFF_GAP        12'h544
`define RPCR_OFF_RSSI       12'h548
`define RPCR_OFF_STATE      12'h550
`define RPCR_OFF_WHITE      12'h554
`define RPCR_OFF_BCC        12'h560
`define RPCR_OFF_BASE       12'h600
`define RPCR_OFF_PREFIX     12'h620
`define RPCR_OFF_MATCH_CFG  12'h640
`define RPCR_ARRAY_MASK     12'hfe0

// ****************************************************************
// Field widths and positions
// ****************************************************************
`define RPCR_ADDR_W         12
`define RPCR_CRC_W          24
`define RPCR_PREFIX_W       16
`define RPCR_SEVEN_W        7
`define RPCR_STATE_W        4
`define RPCR_ENTRIES        8
`define RPCR_IDX_W          3
`define RPCR_IDX_LSB        2
`define RPCR_CFG_W          16
`define RPCR_CFG_TXADD_LSB  8
`define RPCR_WHITE_FIXED    6

// ****************************************************************
// Reset values
// ****************************************************************
`define RPCR_RST_WHITE      7'h40

// ****************************************************************
// Radio state codes
// ****************************************************************
`define RPCR_ST_DISABLED    4'h0
`define RPCR_ST_RX_RAMPUP   4'h1
`define RPCR_ST_RX_IDLE     4'h2
`define RPCR_ST_RX          4'h3
`define RPCR_ST_RX_DISABLE  4'h4
`define RPCR_ST_TX_RAMPUP   4'h9
`define RPCR_ST_TX_IDLE     4'ha
`define RPCR_ST_TX          4'hb
`define RPCR_ST_TX_DISABLE  4'hc

`endif

//--- rpcr_pkg.sv
// Types shared by the radio config bank modules
`include "rpcr_consts.svh"
package rpcr_pkg;

	// Register bank and bus answer state of the top module
	typedef struct packed {
		logic [`RPCR_CRC_W-1:0]    crc_seed;
		logic [31:0]               gap;
		logic [`RPCR_SEVEN_W-1:0]  rssi;
		logic [`RPCR_STATE_W-1:0]  state;
		logic [`RPCR_SEVEN_W-1:0]  white;
		logic [31:0]               bcc;
		logic [`RPCR_CFG_W-1:0]    cfg;
		logic [`RPCR_ENTRIES-1:0]  hit;
		logic                      hit_valid;
		logic [31:0]               prdata;
		logic                      pready;
		logic                      pslverr;
	} rpcr_regs_t;

	// Address table state
	typedef struct packed {
		logic [`RPCR_ENTRIES-1:0][31:0]               base;
		logic [`RPCR_ENTRIES-1:0][`RPCR_PREFIX_W-1:0] prefix;
		logic [31:0]                                  rd_data;
	} rpcr_mem_t;

endpackage

//--- rpcr_mem_if.sv
// Link between the register bank and its address table
`timescale 1ns/1ps
`include "rpcr_consts.svh"
interface rpcr_mem_if;
	import rpcr_pkg::*;
	logic                      wr_en;
	logic                      wr_prefix;
	logic [`RPCR_IDX_W-1:0]    wr_idx;
	logic [31:0]               wr_data;
	logic                      rd_prefix;
	logic [`RPCR_IDX_W-1:0]    rd_idx;
	logic [31:0]               rd_data;
	logic [31:0]               cand_base;
	logic [`RPCR_PREFIX_W-1:0] cand_prefix;
	logic [`RPCR_ENTRIES-1:0]  hit;

	modport ctrl (
		output wr_en, wr_prefix, wr_idx, wr_data,
		output rd_prefix, rd_idx, cand_base, cand_prefix,
		input  rd_data, hit
	);
	modport store (
		input  wr_en, wr_prefix, wr_idx, wr_data,
		input  rd_prefix, rd_idx, cand_base, cand_prefix,
		output rd_data, hit
	);
endinterface // rpcr_mem_if

//--- rpcr_addr_store.sv
// Device address base and prefix table with registered read port
`timescale 1ns/1ps
`include "rpcr_consts.svh"
module rpcr_addr_store
	import rpcr_pkg::*;
(
	input  logic         clock,
	input  logic         rst,
	rpcr_mem_if.store    bus
);

	rpcr_mem_t m_q;
	rpcr_mem_t m_d;

	// Write one entry, register the read word every cycle
	always_comb begin
		m_d = m_q;
		if (bus.wr_en) begin
			if (bus.wr_prefix)
				m_d.prefix[bus.wr_idx] = bus.wr_data[`RPCR_PREFIX_W-1:0];
			else
				m_d.base[bus.wr_idx] = bus.wr_data;
		end
		m_d.rd_data = bus.rd_prefix ? {16'h0000, m_q.prefix[bus.rd_idx]}
			: m_q.base[bus.rd_idx];
	end

	// All entries clear at reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			m_q <= '0;
		else
			m_q <= m_d;
	end

	assign bus.rd_data = m_q.rd_data;

	// Parallel compare, one comparator per entry
	genvar g;
	generate
		for (g = 0; g < `RPCR_ENTRIES; g++) begin : g_cmp
			assign bus.hit[g] = (m_q.base[g] == bus.cand_base) &&
				(m_q.prefix[g] == bus.cand_prefix);
		end
	endgenerate

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence s_base_wr;
		bus.wr_en && !bus.wr_prefix;
	endsequence
	sequence s_prefix_wr;
		bus.wr_en && bus.wr_prefix;
	endsequence
	property p_base_write;
		@(posedge clock) disable iff (rst)
		s_base_wr |=> m_q.base[$past(bus.wr_idx)] == $past(bus.wr_data);
	endproperty
	a_base_write: assert property (p_base_write)
		else $error("base entry did not take written word");
	property p_prefix_write;
		@(posedge clock) disable iff (rst)
		s_prefix_wr |=> {16'h0000, m_q.prefix[$past(bus.wr_idx)]} ==
			($past(bus.wr_data) & 32'h0000_ffff);
	endproperty
	a_prefix_write: assert property (p_prefix_write)
		else $error("prefix entry did not take written word");

endmodule // rpcr_addr_store

//--- rpcr_regs.sv
// APB register bank of the packet radio configuration slice
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "rpcr_consts.svh"
module rpcr_regs
	import rpcr_pkg::*;
(
	input  logic                       clock,
	input  logic                       rst,
	input  logic                       psel,
	input  logic                       penable,
	input  logic                       pwrite,
	input  logic [`RPCR_ADDR_W-1:0]    paddr,
	input  logic [31:0]                pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  logic [`RPCR_STATE_W-1:0]   radio_state_code,
	input  logic                       rssi_valid,
	input  logic [`RPCR_SEVEN_W-1:0]   rssi_value,
	input  logic                       match_req,
	input  logic [31:0]                match_base,
	input  logic [`RPCR_PREFIX_W-1:0]  match_prefix,
	output logic [`RPCR_CRC_W-1:0]     crc_seed,
	output logic [31:0]                interframe_gap,
	output logic [`RPCR_SEVEN_W-1:0]   whitening_seed,
	output logic [31:0]                bit_count_compare,
	output logic [`RPCR_SEVEN_W-1:0]   signal_strength_sample,
	output logic [`RPCR_STATE_W-1:0]   radio_state,
	output logic [`RPCR_ENTRIES-1:0]   match_enable,
	output logic [`RPCR_ENTRIES-1:0]   match_txadd,
	output logic                       match_valid,
	output logic [`RPCR_ENTRIES-1:0]   match_hit
);

	// ****************************************************************
	// State and address table
	// ****************************************************************
	rpcr_regs_t s_q;
	rpcr_regs_t s_d;
	rpcr_mem_if mem_bus ();

	logic       in_array;
	logic       in_prefix;
	logic       wr_fire;

	rpcr_addr_store rpcr_addr_store_i (
		.clock (clock),
		.rst   (rst),
		.bus   (mem_bus)
	);

	// ****************************************************************
	// Address decode towards the table
	// ****************************************************************

	// Both tables share one window; bit 5 of the offset picks the half
	assign in_array  = ((paddr & `RPCR_ARRAY_MASK) == `RPCR_OFF_BASE) ||
		((paddr & `RPCR_ARRAY_MASK) == `RPCR_OFF_PREFIX);
	assign in_prefix = (paddr & `RPCR_ARRAY_MASK) == `RPCR_OFF_PREFIX;

	// Writes land only on the edge that completes the transfer
	assign wr_fire = psel && penable && pwrite && s_q.pready &&
		!s_q.pslverr;

	// Table strobes; the index is the word number inside its half of the window
	assign mem_bus.wr_en       = wr_fire && in_array;
	assign mem_bus.wr_prefix   = in_prefix;
	assign mem_bus.wr_idx      = paddr[`RPCR_IDX_LSB+:`RPCR_IDX_W];
	assign mem_bus.wr_data     = pwdata;
	assign mem_bus.rd_prefix   = in_prefix;
	assign mem_bus.rd_idx      = paddr[`RPCR_IDX_LSB+:`RPCR_IDX_W];
	assign mem_bus.cand_base   = match_base;
	assign mem_bus.cand_prefix = match_prefix;

	// ****************************************************************
	// Next state
	// ****************************************************************

	// One process fills the whole next state; the table read is
	// registered, so every access waits one cycle for its answer
	always_comb begin
		logic [31:0] rd_word;
		logic        mapped;
		rd_word = 32'h0000_0000;
		mapped  = 1'b1;
		s_d     = s_q;

		// Read multiplexer; unmapped offsets read zero
		if (in_array) begin
			rd_word = mem_bus.rd_data;
		end else begin
			case (paddr)
				`RPCR_OFF_CRC_SEED: begin
					rd_word = {8'h00, s_q.crc_seed};
				end
				`RPCR_OFF_GAP: begin
					rd_word = s_q.gap;
				end
				`RPCR_OFF_RSSI: begin
					rd_word = {25'h000_0000, s_q.rssi};
				end
				`RPCR_OFF_STATE: begin
					rd_word = {28'h000_0000, s_q.state};
				end
				`RPCR_OFF_WHITE: begin
					rd_word = {25'h000_0000, s_q.white};
				end
				`RPCR_OFF_BCC: begin
					rd_word = s_q.bcc;
				end
				`RPCR_OFF_MATCH_CFG: begin
					rd_word = {16'h0000, s_q.cfg};
				end
				default: begin
					mapped = 1'b0;
				end
			endcase
		end

		// Radio state follows the sequencer; a code outside the
		// legal set is dropped so software never reads a bogus one
		case (radio_state_code)
			`RPCR_ST_DISABLED,
			`RPCR_ST_RX_RAMPUP,
			`RPCR_ST_RX_IDLE,
			`RPCR_ST_RX,
			`RPCR_ST_RX_DISABLE: begin
				s_d.state = radio_state_code;
			end
			`RPCR_ST_TX_RAMPUP,
			`RPCR_ST_TX_IDLE,
			`RPCR_ST_TX,
			`RPCR_ST_TX_DISABLE: begin
				s_d.state = radio_state_code;
			end
			default: begin
				s_d.state = s_q.state;
			end
		endcase

		// Strength sample: magnitude only, the sign is implied
		if (rssi_valid) begin
			s_d.rssi = rssi_value;
		end

		// Match result, gated per index by its enable bit
		s_d.hit_valid = match_req;
		if (match_req) begin
			s_d.hit = mem_bus.hit & s_q.cfg[`RPCR_ENTRIES-1:0];
		end

		// Bus answer: one wait cycle, then pready for one cycle
		if (s_q.pready) begin
			s_d.pready  = 1'b0;
			s_d.pslverr = 1'b0;
			s_d.prdata  = 32'h0000_0000;
			if (wr_fire && !in_array) begin
				case (paddr)
					`RPCR_OFF_CRC_SEED: begin
						s_d.crc_seed = pwdata[`RPCR_CRC_W-1:0];
					end
					`RPCR_OFF_GAP: begin
						s_d.gap = pwdata;
					end
					`RPCR_OFF_WHITE: begin
						// Bit 6 cannot be cleared by a write
						s_d.white = pwdata[`RPCR_SEVEN_W-1:0] |
							`RPCR_RST_WHITE;
					end
					`RPCR_OFF_BCC: begin
						s_d.bcc = pwdata;
					end
					`RPCR_OFF_MATCH_CFG: begin
						s_d.cfg = pwdata[`RPCR_CFG_W-1:0];
					end
					default: begin
						// Read-only offsets ignore writes
						s_d.cfg = s_q.cfg;
					end
				endcase
			end
		end else if (psel && penable) begin
			s_d.pready  = 1'b1;
			s_d.pslverr = !mapped;
			s_d.prdata  = pwrite ? 32'h0000_0000 : rd_word;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************

	// Everything clears except the whitening seed and its fixed bit
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q       <= '0;
			s_q.white <= `RPCR_RST_WHITE;
		end else begin
			s_q       <= s_d;
		end
	end

	// ****************************************************************
	// Outputs, all straight from the state register
	// ****************************************************************
	assign prdata                 = s_q.prdata;
	assign pready                 = s_q.pready;
	assign pslverr                = s_q.pslverr;
	assign crc_seed               = s_q.crc_seed;
	assign interframe_gap         = s_q.gap;
	assign whitening_seed         = s_q.white;
	assign bit_count_compare      = s_q.bcc;
	assign signal_strength_sample = s_q.rssi;
	assign radio_state            = s_q.state;
	assign match_enable           = s_q.cfg[`RPCR_ENTRIES-1:0];
	assign match_txadd            = s_q.cfg[`RPCR_CFG_W-1:`RPCR_CFG_TXADD_LSB];
	assign match_valid            = s_q.hit_valid;
	assign match_hit              = s_q.hit;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Helper: a write completing at this edge
	logic wr_done;
	assign wr_done = psel && penable && pready && pwrite && !pslverr;

	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence

	// Answer comes in the second access cycle, never the first
	property p_apb_wait;
		s_setup ##1 s_access |-> !pready ##1 pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait)
		else $error("access answer not in second access cycle");

	property p_crc_write;
		wr_done && paddr == `RPCR_OFF_CRC_SEED |=>
			{8'h00, crc_seed} == ($past(pwdata) & 32'h00ff_ffff);
	endproperty
	a_crc_write: assert property (p_crc_write)
		else $error("crc seed did not take written value");

	property p_gap_write;
		wr_done && paddr == `RPCR_OFF_GAP |=>
			interframe_gap == $past(pwdata);
	endproperty
	a_gap_write: assert property (p_gap_write)
		else $error("gap register did not take written value");

	property p_state_rx;
		radio_state_code inside {`RPCR_ST_DISABLED, `RPCR_ST_RX_RAMPUP,
			`RPCR_ST_RX_IDLE, `RPCR_ST_RX, `RPCR_ST_RX_DISABLE} |=>
			radio_state == $past(radio_state_code);
	endproperty
	a_state_rx: assert property (p_state_rx)
		else $error("receive state code not reported");

	property p_state_tx;
		radio_state_code inside {`RPCR_ST_TX_RAMPUP, `RPCR_ST_TX_IDLE,
			`RPCR_ST_TX, `RPCR_ST_TX_DISABLE} |=>
			radio_state == $past(radio_state_code);
	endproperty
	a_state_tx: assert property (p_state_tx)
		else $error("transmit state code not reported");

	property p_white_write;
		wr_done && paddr == `RPCR_OFF_WHITE |=>
			{25'h000_0000, whitening_seed} ==
			(($past(pwdata) & 32'h0000_007f) | 32'h0000_0040);
	endproperty
	a_white_write: assert property (p_white_write)
		else $error("whitening seed write or fixed bit wrong");

	property p_bcc_write;
		wr_done && paddr == `RPCR_OFF_BCC |=>
			bit_count_compare == $past(pwdata);
	endproperty
	a_bcc_write: assert property (p_bcc_write)
		else $error("bit count compare did not take written value");

	property p_match_gate;
		match_req |=> match_valid &&
			((match_hit & ~$past(match_enable)) == 8'h00);
	endproperty
	a_match_gate: assert property (p_match_gate)
		else $error("match reported on a disabled index");

	property p_rssi_take;
		rssi_valid |=> signal_strength_sample == $past(rssi_value);
	endproperty
	a_rssi_take: assert property (p_rssi_take)
		else $error("strength sample not captured");

	// Answer strobe stands exactly one cycle; a held select
	// completes another transfer two cycles later
	property p_pready_pulse;
		pready |=> !pready;
	endproperty
	a_pready_pulse: assert property (p_pready_pulse)
		else $error("pready stood longer than one cycle");

	property p_white_fixed;
		whitening_seed[`RPCR_WHITE_FIXED];
	endproperty
	a_white_fixed: assert property (p_white_fixed)
		else $error("whitening seed fixed bit seen low");

	property p_state_hold;
		!(radio_state_code inside {`RPCR_ST_DISABLED, `RPCR_ST_RX_RAMPUP,
			`RPCR_ST_RX_IDLE, `RPCR_ST_RX, `RPCR_ST_RX_DISABLE,
			`RPCR_ST_TX_RAMPUP, `RPCR_ST_TX_IDLE, `RPCR_ST_TX,
			`RPCR_ST_TX_DISABLE}) |=> $stable(radio_state);
	endproperty
	a_state_hold: assert property (p_state_hold)
		else $error("unlisted state code changed the report");

	property p_ro_ignore;
		wr_done && paddr == `RPCR_OFF_RSSI && !rssi_valid |=>
			$stable(signal_strength_sample);
	endproperty
	a_ro_ignore: assert property (p_ro_ignore)
		else $error("write reached the strength sample");

	property p_cfg_write;
		wr_done && paddr == `RPCR_OFF_MATCH_CFG |=>
			{16'h0000, match_txadd, match_enable} ==
			($past(pwdata) & 32'h0000_ffff);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("match config did not take written value");

endmodule // rpcr_regs

//--- test_rpcr_regs.sv
// Self-checking bench for the radio configuration register bank
`timescale 1ns/1ps
`include "rpcr_consts.svh"
module test_rpcr_regs;
	import rpcr_pkg::*;
	logic        clock, rst, psel, penable, pwrite, rssi_valid, match_req;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, match_base, gap, bcc;
	logic        pready, pslverr, match_valid;
	logic [3:0]  radio_state_code, radio_state;
	logic [6:0]  rssi_value, white, rssi;
	logic [15:0] match_prefix;
	logic [23:0] crc;
	logic [7:0]  m_en, m_tx, m_hit;
	int          num_errors, n_checks;
	logic [3:0]  codes [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4,
		4'h9, 4'ha, 4'hb, 4'hc};

	rpcr_regs rpcr_regs_i (.clock(clock), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .radio_state_code(radio_state_code),
		.rssi_valid(rssi_valid), .rssi_value(rssi_value),
		.match_req(match_req), .match_base(match_base),
		.match_prefix(match_prefix), .crc_seed(crc),
		.interframe_gap(gap), .whitening_seed(white),
		.bit_count_compare(bcc), .signal_strength_sample(rssi),
		.radio_state(radio_state), .match_enable(m_en),
		.match_txadd(m_tx), .match_valid(match_valid),
		.match_hit(m_hit));

	// ****************************************************************
	// Clock and watchdog
	// ****************************************************************
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// Whole run is a few hundred cycles; this bound leaves wide margin
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		report_and_stop();
	end

	// ****************************************************************
	// Compare and bus tasks
	// ****************************************************************
	task automatic check_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp,
		input logic got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, got);
		end
	endtask

	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check_bit("pready", 1'b1, pready);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		check_bit("write pslverr", 1'b0, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp,
		input logic experr);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check_word($sformatf("read %h", a), exp, r);
		check_bit("read pslverr", experr, e);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// Test sequence
	// ****************************************************************
	initial begin
		num_errors = 0;
		n_checks = 0;
		rst = 1'b1;
		{psel, penable, pwrite, rssi_valid, match_req} = '0;
		paddr = '0;
		pwdata = '0;
		radio_state_code = 4'h0;
		rssi_value = '0;
		match_base = '0;
		match_prefix = '0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);

		// Reset values of every register except the strength sample
		rd(`RPCR_OFF_CRC_SEED, 32'h0000_0000, 1'b0);
		rd(`RPCR_OFF_GAP, 32'h0000_0000, 1'b0);
		rd(`RPCR_OFF_STATE, 32'h0000_0000, 1'b0);
		rd(`RPCR_OFF_WHITE, 32'h0000_0040, 1'b0);
		check_word("whitening out", 32'h0000_0040, {25'd0, white});
		rd(`RPCR_OFF_BCC, 32'h0000_0000, 1'b0);
		rd(`RPCR_OFF_MATCH_CFG, 32'h0000_0000, 1'b0);
		for (int i = 0; i < 8; i++) begin
			rd(`RPCR_OFF_BASE + 12'(4 * i), 32'h0000_0000, 1'b0);
			rd(`RPCR_OFF_PREFIX + 12'(4 * i), 32'h0000_0000, 1'b0);
		end
		$display("test reset done");

		// Read-write registers, narrow fields and the fixed bit
		wr(`RPCR_OFF_CRC_SEED, 32'hffff_ffff);
		rd(`RPCR_OFF_CRC_SEED, 32'h00ff_ffff, 1'b0);
		check_word("crc out", 32'h00ff_ffff, {8'd0, crc});
		wr(`RPCR_OFF_GAP, 32'h8000_0096);
		rd(`RPCR_OFF_GAP, 32'h8000_0096, 1'b0);
		check_word("gap out", 32'h8000_0096, gap);
		wr(`RPCR_OFF_WHITE, 32'h0000_0000);
		rd(`RPCR_OFF_WHITE, 32'h0000_0040, 1'b0);
		wr(`RPCR_OFF_WHITE, 32'hffff_ff3f);
		rd(`RPCR_OFF_WHITE, 32'h0000_007f, 1'b0);
		check_word("whitening out", 32'h0000_007f, {25'd0, white});
		wr(`RPCR_OFF_BCC, 32'hdead_0001);
		rd(`RPCR_OFF_BCC, 32'hdead_0001, 1'b0);
		check_word("bcc out", 32'hdead_0001, bcc);
		$display("test read write done");

		// Address table: fill all entries before reading any back
		for (int i = 0; i < 8; i++) begin
			wr(`RPCR_OFF_BASE + 12'(4 * i), 32'ha5a5_0000 | i);
			wr(`RPCR_OFF_PREFIX + 12'(4 * i), 32'hffff_0000 | i);
		end
		for (int i = 0; i < 8; i++) begin
			rd(`RPCR_OFF_BASE + 12'(4 * i), 32'ha5a5_0000 | i, 1'b0);
			rd(`RPCR_OFF_PREFIX + 12'(4 * i), 32'h0000_0000 | i, 1'b0);
		end
		$display("test address table done");

		// Matching honours only enabled indexes
		wr(`RPCR_OFF_MATCH_CFG, 32'h0000_ff05);
		check_word("enables", 32'h0000_0005, {24'd0, m_en});
		check_word("txadd", 32'h0000_00ff, {24'd0, m_tx});
		for (int i = 0; i < 4; i++) begin
			match_req    <= 1'b1;
			match_base   <= 32'ha5a5_0000 | i;
			match_prefix <= 16'(i);
			@(posedge clock);
			match_req <= 1'b0;
			#1;
			check_bit("match valid", 1'b1, match_valid);
			check_word("match hit", 32'(((8'h05 >> i) & 8'h01) << i),
				{24'd0, m_hit});
			@(posedge clock);
		end
		$display("test match done");

		// Every state code is reported, an unlisted code is not
		for (int i = 0; i < 10; i++) begin
			radio_state_code <= (i < 9) ? codes[i] : 4'h5;
			repeat (2) @(posedge clock);
			rd(`RPCR_OFF_STATE, {28'd0, codes[(i < 9) ? i : 8]}, 1'b0);
		end
		check_word("state out", 32'h0000_000c, {28'd0, radio_state});

		// Strength sample at the top of its range
		rssi_valid <= 1'b1;
		rssi_value <= 7'h7f;
		@(posedge clock);
		rssi_valid <= 1'b0;
		rssi_value <= 7'h00;
		@(posedge clock);
		rd(`RPCR_OFF_RSSI, 32'h0000_007f, 1'b0);
		check_word("rssi out", 32'h0000_007f, {25'h000_0000, rssi});
		$display("test status done");

		// Writes to read-only places are dropped, an unmapped read is refused
		wr(`RPCR_OFF_STATE, 32'h0000_0003);
		wr(`RPCR_OFF_RSSI, 32'h0000_0011);
		rd(`RPCR_OFF_STATE, 32'h0000_000c, 1'b0);
		rd(`RPCR_OFF_RSSI, 32'h0000_007f, 1'b0);
		rd(12'h700, 32'h0000_0000, 1'b1);
		$display("test access kinds done");
		report_and_stop();
	end
endmodule // test_rpcr_regs
